// [rtl/agsc_pkg.sv]
package agsc_pkg;
   // Byte offsets inside the converter's window; each result word is upper then lower byte
   localparam logic [7:0] OFS_RESULT_BASE = 8'h00;
   localparam logic [7:0] OFS_RESULT_UPPER_BASE = 8'h20;
   localparam logic [7:0] OFS_CTRL_STATUS = 8'h18;
   localparam logic [7:0] OFS_START_CTRL = 8'h19;
   localparam logic [7:0] OFS_TRIG_SOURCE = 8'h28;

   localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
   localparam logic [7:0] RST_START_CTRL = 8'h1F;
   localparam logic [7:0] RST_TRIG_SOURCE = 8'hFF;
   localparam logic [15:0] RST_RESULT = 16'h0000;

   // Bits that read back as constant ones
   localparam logic [7:0] START_CTRL_FIXED = 8'h1F;
   localparam logic [7:0] TRIG_SOURCE_FIXED = 8'h7F;

   localparam int BIT_END_FLAG = 7;
   localparam int BIT_IRQ_EN = 6;
   localparam int BIT_SCAN_HI = 5;
   localparam int BIT_SCAN_LO = 4;
   localparam int BIT_TRG_EN = 7;
   localparam int BIT_SPEED = 6;
   localparam int BIT_RUN = 5;
   localparam int BIT_TRG_SEL = 7;

   localparam int RES_W = 10;
   localparam int NUM_RESULTS = 16;
   localparam int CONV_STATES_SLOW = 266;
   localparam int CONV_STATES_FAST = 134;
   localparam int CNT_W = 9;

   typedef enum logic [1:0] {SCAN_SINGLE, SCAN_FOUR, SCAN_EIGHT, SCAN_TWELVE} agsc_scan_t;
   typedef enum logic {ST_IDLE, ST_CONV} agsc_state_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } agsc_bus_req_t;
endpackage

// [rtl/agsc_result_store.sv]
`timescale 1ns/10ps
module agsc_result_store #(
   parameter int DEPTH = 16,
   parameter int DATA_W = 10
) (
   input wire logic core_clk_in,
   input wire logic clear_in,
   input wire logic wr_en_in,
   input wire logic [$clog2(DEPTH)-1:0] wr_idx_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic [$clog2(DEPTH)-1:0] rd_idx_in,
   output logic [DATA_W-1:0] rd_data_out
);
   logic [DATA_W-1:0] mem_ff [DEPTH];

   if (DEPTH < 2 || DEPTH != (1 << $clog2(DEPTH)) || DATA_W < 1) begin : g_bad
      $error("Result store needs a power-of-two depth and a nonzero width");
   end

   // Flops rather than a RAM macro: every word must clear at once in standby
   always_ff @(posedge core_clk_in) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (clear_in) begin
            mem_ff[i] <= '0;
         end else if (wr_en_in && wr_idx_in == i[$clog2(DEPTH)-1:0]) begin
            mem_ff[i] <= wr_data_in;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (clear_in) begin
         rd_data_out <= '0;
      end else begin
         rd_data_out <= mem_ff[rd_idx_in];
      end
   end
endmodule // agsc_result_store

// [rtl/agsc_scan_ctrl.sv]
`timescale 1ns/10ps
// Summary of operation
// RULE_01 - Sixteen read-only 16-bit results, zero after reset and in standby.
// RULE_02 - Result upper eight bits in upper byte, low two in bits 7:6.
// RULE_03 - Channel n result lands in result register n.
// RULE_04 - End flag sets after single conversion or each finished scan group.
// RULE_05 - End flag clears by write 0 after reading 1, or DMA acknowledge.
// RULE_06 - Writing 1 to the end flag has no effect.
// RULE_07 - Single mode idles after its result; scan keeps converting.
// RULE_08 - Interrupt asserted while end flag and interrupt enable are both 1.
// RULE_09 - Scan field: single, four, eight, twelve channels; status resets zero.
// RULE_10 - Single mode converts the channel given by the four-bit select.
// RULE_11 - Four-channel scan: upper select bits pick group, lower bits count.
// RULE_12 - Eight and twelve scans cover groups 0-1 or 0-2, same count.
// RULE_13 - Software never uses eight-channel scan with select bit 3 set.
// RULE_14 - Start control resets to 1F; bits 4:0 ignore writes, read 1.
// RULE_15 - Hardware triggers accepted only while trigger enable is 1.
// RULE_16 - Falling trigger pin edge sets run bit like a software start.
// RULE_17 - Trigger edges ignored while the run bit is already 1.
// RULE_18 - Trigger pin held low at least 1.5 clocks per pulse.
// RULE_19 - Timer triggering needs trigger source bit 7 cleared by software.
// RULE_20 - Conversion lasts at most 266 states, or 134 with speed bit.
// RULE_21 - Run bit 1 starts conversion; clearing it halts conversion.
// RULE_22 - Software stops conversion before changing mode or speed settings.
// RULE_23 - Single mode clears the run bit at end; scan leaves it set.
// RULE_24 - Upper byte read latches lower byte; later lower read returns it.
// RULE_25 - Trigger source bit: 0 timer, 1 pin; resets to 1.
// RULE_26 - Channels step upward within a group, then group by group.
// RULE_27 - Trigger pin passes a two-stage synchroniser before edge detection.
module agsc_scan_ctrl #(
   parameter int CONV_SLOW = agsc_pkg::CONV_STATES_SLOW,
   parameter int CONV_FAST = agsc_pkg::CONV_STATES_FAST
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic standby_in,
   input wire agsc_pkg::agsc_bus_req_t bus_req_in,
   output logic [7:0] rdata_out,
   output logic rd_valid_out,
   input wire logic ext_trigger_n_in,
   input wire logic timer_trig_in,
   input wire logic dma_ack_in,
   output logic conv_end_irq_out,
   output logic core_start_out,
   output logic [3:0] core_chan_out,
   output logic conv_speed_select_out,
   input wire logic [agsc_pkg::RES_W-1:0] core_result_in
);
   if (CONV_SLOW < 2 || CONV_FAST < 2 || CONV_SLOW >= 512 || CONV_FAST >= 512) begin : g_bad
      $error("Conversion lengths must lie between 2 and 511 states");
   end

   localparam logic [8:0] LAST_SLOW = 9'(CONV_SLOW - 1);
   localparam logic [8:0] LAST_FAST = 9'(CONV_FAST - 1);

   logic clr;
   logic [7:0] ctrl_status_ff;
   logic run_ff, trg_en_ff, speed_ff, trg_sel_ff, armed_ff;
   logic ext_sync1_ff, ext_sync2_ff, ext_prev_ff;
   agsc_pkg::agsc_state_t state_ff;
   logic [1:0] grp_ff, idx_ff;
   logic [8:0] cnt_ff;
   logic [3:0] chan_ff;
   logic start_ff, rd_pend_ff, rd_res_ff, rd_valid_ff;
   logic [7:0] rd_addr_ff, temp_ff, rdata_ff;
   logic [agsc_pkg::RES_W-1:0] mem_q;

   agsc_pkg::agsc_scan_t mode;
   logic single;
   logic [1:0] first_grp, last_grp;
   logic [8:0] last_cnt;
   logic conv_done, grp_done, ext_fall, hw_start;
   logic wr_status, wr_start, wr_trig, flag_set, flag_clr;
   logic [3:0] wr_chan, rd_idx, cap_idx;
   logic rd_is_result, rd_is_upper;

   assign clr = !rstn_in || standby_in;
   assign wr_status = bus_req_in.wr && bus_req_in.addr == agsc_pkg::OFS_CTRL_STATUS;
   assign wr_start = bus_req_in.wr && bus_req_in.addr == agsc_pkg::OFS_START_CTRL;
   assign wr_trig = bus_req_in.wr && bus_req_in.addr == agsc_pkg::OFS_TRIG_SOURCE;

   // Mode and channel decode
   always_comb begin
      mode = agsc_pkg::agsc_scan_t'({ctrl_status_ff[agsc_pkg::BIT_SCAN_HI],
                                     ctrl_status_ff[agsc_pkg::BIT_SCAN_LO]}); // [RULE_09]
      single = mode == agsc_pkg::SCAN_SINGLE;
      first_grp = 2'h0;
      last_grp = 2'h0;
      case (mode)
         agsc_pkg::SCAN_FOUR: begin
            first_grp = ctrl_status_ff[3:2]; // [RULE_11]
            last_grp = ctrl_status_ff[3:2];
         end
         agsc_pkg::SCAN_EIGHT: begin
            last_grp = 2'h1; // [RULE_12]
         end
         agsc_pkg::SCAN_TWELVE: begin
            last_grp = 2'h2; // [RULE_12]
         end
         default: begin
            last_grp = 2'h0;
         end
      endcase
      last_cnt = speed_ff ? LAST_FAST : LAST_SLOW; // [RULE_20]
      // Single mode takes the select code whole; scans build group and index
      wr_chan = single ? ctrl_status_ff[3:0] : {grp_ff, idx_ff}; // [RULE_10] [RULE_26]
   end

   assign conv_done = state_ff == agsc_pkg::ST_CONV && run_ff && cnt_ff == last_cnt;
   assign grp_done = idx_ff == ctrl_status_ff[1:0];
   assign flag_set = conv_done && (single || grp_done); // [RULE_04]

   // Trigger pin synchroniser and edge detect
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         ext_sync1_ff <= 1'b1;
         ext_sync2_ff <= 1'b1;
         ext_prev_ff <= 1'b1;
      end else begin
         ext_sync1_ff <= ext_trigger_n_in; // [RULE_27]
         ext_sync2_ff <= ext_sync1_ff;
         ext_prev_ff <= ext_sync2_ff;
      end
   end

   // Pulses shorter than one clock may be missed by the synchroniser
   assign ext_fall = ext_prev_ff && !ext_sync2_ff; // [RULE_16]
   assign hw_start = trg_en_ff && !run_ff &&
                     (trg_sel_ff ? ext_fall : timer_trig_in); // [RULE_15] [RULE_17] [RULE_25]

   // Control and status register
   always_ff @(posedge core_clk_in) begin
      if (clr) begin
         ctrl_status_ff[6:0] <= agsc_pkg::RST_CTRL_STATUS[6:0]; // [RULE_09]
      end else if (wr_status) begin
         ctrl_status_ff[6:0] <= bus_req_in.wdata[6:0];
      end
   end

   // Software only clears; a writer holding 1 in bit 7 leaves the flag alone
   assign flag_clr = dma_ack_in ||
                     (wr_status && armed_ff &&
                      !bus_req_in.wdata[agsc_pkg::BIT_END_FLAG]); // [RULE_05] [RULE_06]

   always_ff @(posedge core_clk_in) begin
      if (clr) begin
         ctrl_status_ff[agsc_pkg::BIT_END_FLAG] <=
            agsc_pkg::RST_CTRL_STATUS[agsc_pkg::BIT_END_FLAG];
      end else if (flag_set) begin
         ctrl_status_ff[agsc_pkg::BIT_END_FLAG] <= 1'b1; // [RULE_04]
      end else if (flag_clr) begin
         ctrl_status_ff[agsc_pkg::BIT_END_FLAG] <= 1'b0; // [RULE_05]
      end
   end

   // Read of the flag as 1 arms the clear; any status write disarms it
   always_ff @(posedge core_clk_in) begin
      if (clr) begin
         armed_ff <= 1'b0;
      end else if (wr_status) begin
         armed_ff <= 1'b0;
      end else if (rd_pend_ff && rd_addr_ff == agsc_pkg::OFS_CTRL_STATUS &&
                   ctrl_status_ff[agsc_pkg::BIT_END_FLAG]) begin
         armed_ff <= 1'b1; // [RULE_05]
      end
   end

   assign conv_end_irq_out = ctrl_status_ff[agsc_pkg::BIT_END_FLAG] &&
                             ctrl_status_ff[agsc_pkg::BIT_IRQ_EN]; // [RULE_08]

   // Start control and trigger source
   always_ff @(posedge core_clk_in) begin
      if (clr) begin
         trg_en_ff <= agsc_pkg::RST_START_CTRL[agsc_pkg::BIT_TRG_EN];
         speed_ff <= agsc_pkg::RST_START_CTRL[agsc_pkg::BIT_SPEED];
         trg_sel_ff <= agsc_pkg::RST_TRIG_SOURCE[agsc_pkg::BIT_TRG_SEL]; // [RULE_25]
      end else begin
         if (wr_start) begin
            trg_en_ff <= bus_req_in.wdata[agsc_pkg::BIT_TRG_EN]; // [RULE_15]
            speed_ff <= bus_req_in.wdata[agsc_pkg::BIT_SPEED];
         end
         if (wr_trig) begin
            trg_sel_ff <= bus_req_in.wdata[agsc_pkg::BIT_TRG_SEL]; // [RULE_19]
         end
      end
   end

   assign conv_speed_select_out = speed_ff;

   // Run bit: a software write beats the single-mode auto clear in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (clr) begin
         run_ff <= agsc_pkg::RST_START_CTRL[agsc_pkg::BIT_RUN];
      end else if (wr_start) begin
         run_ff <= bus_req_in.wdata[agsc_pkg::BIT_RUN]; // [RULE_21]
      end else if (hw_start) begin
         run_ff <= 1'b1; // [RULE_16]
      end else if (conv_done && single) begin
         run_ff <= 1'b0; // [RULE_23]
      end
   end

   // Conversion sequencer
   always_ff @(posedge core_clk_in) begin
      if (clr) begin
         state_ff <= agsc_pkg::ST_IDLE;
         grp_ff <= 2'h0;
         idx_ff <= 2'h0;
         cnt_ff <= 9'h000;
         start_ff <= 1'b0;
         chan_ff <= 4'h0;
      end else begin
         start_ff <= 1'b0;
         case (state_ff)
            agsc_pkg::ST_IDLE: begin
               cnt_ff <= 9'h000;
               if (run_ff) begin
                  state_ff <= agsc_pkg::ST_CONV; // [RULE_21]
                  grp_ff <= first_grp;
                  idx_ff <= 2'h0;
                  start_ff <= 1'b1;
                  chan_ff <= single ? ctrl_status_ff[3:0] : {first_grp, 2'h0};
               end
            end
            agsc_pkg::ST_CONV: begin
               if (!run_ff) begin
                  state_ff <= agsc_pkg::ST_IDLE; // [RULE_21]
               end else if (!conv_done) begin
                  cnt_ff <= cnt_ff + 9'h001;
               end else if (single) begin
                  state_ff <= agsc_pkg::ST_IDLE; // [RULE_07]
               end else begin
                  // Scan wraps to its first group and runs until software stops it
                  cnt_ff <= 9'h000; // [RULE_07]
                  start_ff <= 1'b1;
                  if (grp_done) begin
                     idx_ff <= 2'h0; // [RULE_26]
                     grp_ff <= (grp_ff == last_grp) ? first_grp : grp_ff + 2'h1;
                     chan_ff <= {(grp_ff == last_grp) ? first_grp : grp_ff + 2'h1, 2'h0};
                  end else begin
                     idx_ff <= idx_ff + 2'h1; // [RULE_26]
                     chan_ff <= {grp_ff, idx_ff + 2'h1};
                  end
               end
            end
            default: begin
               state_ff <= agsc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign core_start_out = start_ff;
   assign core_chan_out = chan_ff;

   // Result storage and byte reads
   always_comb begin
      rd_is_result = 1'b0;
      rd_idx = 4'h0;
      if (bus_req_in.addr < agsc_pkg::OFS_CTRL_STATUS) begin
         rd_is_result = 1'b1;
         rd_idx = bus_req_in.addr[4:1];
      end else if (bus_req_in.addr[7:3] == agsc_pkg::OFS_RESULT_UPPER_BASE[7:3]) begin
         rd_is_result = 1'b1;
         rd_idx = {2'b11, bus_req_in.addr[2:1]};
      end
   end

   assign cap_idx = wr_chan; // [RULE_03]

   agsc_result_store #(
      .DEPTH(agsc_pkg::NUM_RESULTS),
      .DATA_W(agsc_pkg::RES_W)
   ) u_store (
      .core_clk_in(core_clk_in),
      .clear_in(clr), // [RULE_01]
      .wr_en_in(conv_done),
      .wr_idx_in(cap_idx),
      .wr_data_in(core_result_in),
      .rd_idx_in(rd_idx),
      .rd_data_out(mem_q)
   );

   always_ff @(posedge core_clk_in) begin
      if (clr) begin
         rd_pend_ff <= 1'b0;
         rd_addr_ff <= 8'h00;
         rd_res_ff <= 1'b0;
      end else begin
         rd_pend_ff <= bus_req_in.rd;
         rd_addr_ff <= bus_req_in.addr;
         rd_res_ff <= rd_is_result;
      end
   end

   assign rd_is_upper = !rd_addr_ff[0];

   always_ff @(posedge core_clk_in) begin
      if (clr) begin
         rdata_ff <= 8'h00;
         rd_valid_ff <= 1'b0;
         temp_ff <= agsc_pkg::RST_RESULT[7:0];
      end else begin
         rd_valid_ff <= rd_pend_ff;
         if (rd_pend_ff) begin
            if (rd_addr_ff == agsc_pkg::OFS_CTRL_STATUS) begin
               rdata_ff <= ctrl_status_ff;
            end else if (rd_addr_ff == agsc_pkg::OFS_START_CTRL) begin
               rdata_ff <= {trg_en_ff, speed_ff, run_ff, 5'h00} |
                           agsc_pkg::START_CTRL_FIXED; // [RULE_14]
            end else if (rd_addr_ff == agsc_pkg::OFS_TRIG_SOURCE) begin
               rdata_ff <= {trg_sel_ff, 7'h00} | agsc_pkg::TRIG_SOURCE_FIXED;
            end else if (rd_res_ff) begin
               if (rd_is_upper) begin
                  rdata_ff <= mem_q[9:2]; // [RULE_02]
                  temp_ff <= {mem_q[1:0], 6'h00}; // [RULE_24]
               end else begin
                  rdata_ff <= temp_ff; // [RULE_24]
               end
            end else begin
               rdata_ff <= 8'h00;
            end
         end
      end
   end

   assign rdata_out = rdata_ff;
   assign rd_valid_out = rd_valid_ff;

   logic rd_lower_ff, rd_start_ff;
   always_ff @(posedge core_clk_in) begin
      rd_lower_ff <= rd_pend_ff && rd_addr_ff[0] && rd_addr_ff < agsc_pkg::OFS_CTRL_STATUS;
      rd_start_ff <= rd_pend_ff && rd_addr_ff == agsc_pkg::OFS_START_CTRL;
   end

   flag_set_a: assert property (@(posedge core_clk_in) disable iff (clr) // [RULE_04]
      flag_set |=> ctrl_status_ff[agsc_pkg::BIT_END_FLAG]) else $error("End flag not set");
   no_sw_set_a: assert property (@(posedge core_clk_in) disable iff (clr) // [RULE_06]
      !ctrl_status_ff[agsc_pkg::BIT_END_FLAG] && !flag_set
      |=> !ctrl_status_ff[agsc_pkg::BIT_END_FLAG])
      else $error("End flag set without conversion");
   irq_gate_a: assert property (@(posedge core_clk_in) disable iff (clr) // [RULE_08]
      !ctrl_status_ff[agsc_pkg::BIT_IRQ_EN] |-> !conv_end_irq_out) else $error("Masked irq seen");
   single_stop_a: assert property (@(posedge core_clk_in) disable iff (clr) // [RULE_23]
      conv_done && single && !wr_start |=> !run_ff && state_ff == agsc_pkg::ST_IDLE)
      else $error("Single mode did not stop");
   scan_keep_a: assert property (@(posedge core_clk_in) disable iff (clr) // [RULE_07]
      conv_done && !single && !wr_start |=> run_ff && core_start_out) else $error("Scan halted");
   conv_len_a: assert property (@(posedge core_clk_in) disable iff (clr) // [RULE_20]
      core_start_out |-> ##[1:266] (conv_done || !run_ff)) else $error("Conversion too long");
   trig_start_a: assert property (@(posedge core_clk_in) disable iff (clr) // [RULE_16]
      trg_en_ff && trg_sel_ff && ext_fall && !run_ff && !wr_start |=> run_ff)
      else $error("Trigger edge missed");
   trig_ignore_a: assert property (@(posedge core_clk_in) disable iff (clr) // [RULE_15]
      !trg_en_ff && !wr_start && !run_ff |=> !run_ff) else $error("Disabled trigger started run");
   fixed_ones_a: assert property (@(posedge core_clk_in) disable iff (clr) // [RULE_14]
      rd_start_ff |-> rdata_out[4:0] == 5'h1F) else $error("Reserved bits not one");
   low_fmt_a: assert property (@(posedge core_clk_in) disable iff (clr) // [RULE_02]
      rd_lower_ff |-> rdata_out[5:0] == 6'h00) else $error("Lower byte format wrong");
endmodule // agsc_scan_ctrl

// [testbench/agsc_core_model.sv]
`timescale 1ns/10ps
module agsc_core_model (
   input wire logic core_clk_in,
   input wire logic core_start_in,
   input wire logic [3:0] core_chan_in,
   input wire logic [9:0] salt_in,
   input wire logic trig_req_in,
   output logic [9:0] core_result_out,
   output logic ext_trigger_n_out
);
   logic [1:0] low_cnt_ff = 2'h0;
   logic [9:0] res_ff = 10'h000;
   // Result depends on the channel, so a misrouted conversion lands a wrong value
   always @(posedge core_clk_in) begin
      if (core_start_in) begin
         res_ff <= salt_in + 10'(core_chan_in) * 10'h025;
      end
   end
   assign core_result_out = res_ff;
   // Pin idles high through its pull-up; each pulse stays low for three clocks
   always @(posedge core_clk_in) begin
      if (trig_req_in) begin
         low_cnt_ff <= 2'h3;
      end else if (low_cnt_ff != 2'h0) begin
         low_cnt_ff <= low_cnt_ff - 2'h1;
      end
   end
   assign ext_trigger_n_out = (low_cnt_ff == 2'h0);
endmodule // agsc_core_model

// [testbench/adc_group_scan_control_tb.sv]
`timescale 1ns/10ps
module adc_group_scan_control_tb;
   localparam logic [7:0] ST = agsc_pkg::OFS_CTRL_STATUS;
   localparam logic [7:0] SC = agsc_pkg::OFS_START_CTRL;
   localparam logic [7:0] TS = agsc_pkg::OFS_TRIG_SOURCE;
   logic core_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic standby_in = 1'b0;
   agsc_pkg::agsc_bus_req_t bus_req_in = '0;
   logic timer_trig_in = 1'b0;
   logic dma_ack_in = 1'b0;
   logic trig_req = 1'b0;
   logic [9:0] salt = 10'h000;
   logic [7:0] rdata_out;
   logic rd_valid_out;
   logic conv_end_irq_out;
   logic core_start_out;
   logic conv_speed_select_out;
   logic ext_trigger_n;
   logic [3:0] core_chan_out;
   logic [9:0] core_result;
   logic [7:0] exp_q[$];
   logic [3:0] chan_q[$];
   logic [3:0] chs[3] = '{4'h0, 4'h5, 4'hB};
   logic [7:0] cfg[3] = '{8'h55, 8'h61, 8'h70};
   // Never eight-channel scan with select bit 3 set
   logic [3:0] seq[3][5] = '{'{4'h4, 4'h5, 4'h4, 4'h5, 4'h4}, '{4'h0, 4'h1, 4'h4, 4'h5, 4'h0},
      '{4'h0, 4'h4, 4'h8, 4'h0, 4'h4}};
   int failures = 0;
   int n_compared = 0;
   int n_starts = 0;
   int n0 = 0;
   integer seed = 64973;

   always #25 core_clk_in = ~core_clk_in;

   agsc_scan_ctrl #(.CONV_SLOW(8), .CONV_FAST(4)) agsc_scan_ctrl_i (
      .core_clk_in(core_clk_in), .rstn_in(rstn_in), .standby_in(standby_in),
      .bus_req_in(bus_req_in), .rdata_out(rdata_out), .rd_valid_out(rd_valid_out),
      .ext_trigger_n_in(ext_trigger_n), .timer_trig_in(timer_trig_in),
      .dma_ack_in(dma_ack_in), .conv_end_irq_out(conv_end_irq_out),
      .core_start_out(core_start_out), .core_chan_out(core_chan_out),
      .conv_speed_select_out(conv_speed_select_out), .core_result_in(core_result));

   agsc_core_model agsc_core_model_i (
      .core_clk_in(core_clk_in), .core_start_in(core_start_out), .core_chan_in(core_chan_out),
      .salt_in(salt), .trig_req_in(trig_req), .core_result_out(core_result),
      .ext_trigger_n_out(ext_trigger_n));

   task automatic check(input string what, input logic [7:0] e, input logic [7:0] got);
      n_compared++;
      if (got !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, e, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      bus_req_in <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge core_clk_in);
      bus_req_in <= '0;
   endtask

   // Answer comes one edge after the take edge, so a fixed wait is enough
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge core_clk_in);
      bus_req_in <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge core_clk_in);
      bus_req_in <= '0;
      repeat (3) @(posedge core_clk_in);
   endtask

   task automatic pulse(input int w);
      @(posedge core_clk_in);
      if (w == 0) trig_req <= 1'b1;
      else if (w == 1) timer_trig_in <= 1'b1;
      else dma_ack_in <= 1'b1;
      @(posedge core_clk_in);
      trig_req <= 1'b0;
      timer_trig_in <= 1'b0;
      dma_ack_in <= 1'b0;
   endtask

   task automatic wait_irq(input int lim);
      int i;
      i = 0;
      while (conv_end_irq_out !== 1'b1 && i < lim) begin
         @(negedge core_clk_in);
         i++;
      end
      check("end irq", 8'h01, {7'h00, conv_end_irq_out});
   endtask

   function automatic logic [9:0] expv(input logic [3:0] ch);
      return salt + 10'(ch) * 10'h025;
   endfunction

   task automatic chk_result(input logic [3:0] ch);
      logic [9:0] v;
      v = expv(ch);
      rd(8'(2 * ch), v[9:2]);
      rd(8'(2 * ch + 1), {v[1:0], 6'h00});
   endtask

   always @(negedge core_clk_in) begin
      if (rd_valid_out === 1'b1) begin
         if (exp_q.size() == 0) check("stray read", 8'h00, 8'hFF);
         else check("read data", exp_q.pop_front(), rdata_out);
      end
      if (core_start_out === 1'b1) begin
         n_starts++;
         if (chan_q.size() > 0) begin
            check("channel", {4'h0, chan_q.pop_front()}, {4'h0, core_chan_out});
         end
      end
   end

   // Whole run is under a thousand cycles; this leaves ample slack
   initial begin
      repeat (30000) @(posedge core_clk_in);
      failures++;
      tally_and_finish();
   end

   initial begin
      repeat (10) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      rd(ST, 8'h00);
      rd(SC, 8'h1F);
      rd(TS, 8'hFF);
      rd(8'h3C, 8'h00);
      wr(8'h06, 8'hAA);
      rd(8'h06, 8'h00);
      wr(SC, 8'h00);
      rd(SC, 8'h1F);
      foreach (chs[k]) begin
         salt <= 10'($random(seed));
         chan_q.push_back(chs[k]);
         wr(ST, {4'h4, chs[k]});
         wr(SC, {1'b0, k[0], 6'h20});
         wait_irq(k[0] ? 12 : 16);
         check("speed", {7'h00, k[0]}, {7'h00, conv_speed_select_out});
         rd(SC, {1'b0, k[0], 6'h1F});
         rd(ST, {4'hC, chs[k]});
         wr(ST, {4'hC, chs[k]});
         rd(ST, {4'hC, chs[k]});
         wr(ST, {4'h4, chs[k]});
         @(negedge core_clk_in);
         check("irq after clear", 8'h00, {7'h00, conv_end_irq_out});
         rd(ST, {4'h4, chs[k]});
         chk_result(chs[k]);
      end
      check("single starts", 8'h03, 8'(n_starts));
      foreach (cfg[s]) begin
         salt <= 10'($random(seed));
         for (int j = 0; j < 5; j++) chan_q.push_back(seq[s][j]);
         wr(ST, cfg[s]);
         wr(SC, 8'h60);
         wait_irq(40);
         for (int j = 0; j < 200 && chan_q.size() > 0; j++) @(negedge core_clk_in);
         rd(SC, 8'h7F);
         wr(SC, 8'h40);
         repeat (2) @(posedge core_clk_in);
         n0 = n_starts;
         repeat (20) @(posedge core_clk_in);
         check("starts after stop", 8'(n0), 8'(n_starts));
         for (int j = 0; j < 3; j++) chk_result(seq[s][j]);
         wr(ST, {2'b10, cfg[s][5:0]});
         @(negedge core_clk_in);
         check("irq masked", 8'h00, {7'h00, conv_end_irq_out});
         rd(ST, {2'b10, cfg[s][5:0]});
         pulse(2);
         rd(ST, {2'b00, cfg[s][5:0]});
      end
      salt <= 10'($random(seed));
      wr(ST, 8'h43);
      n0 = n_starts;
      pulse(0);
      repeat (10) @(posedge core_clk_in);
      check("trigger disabled", 8'(n0), 8'(n_starts));
      wr(SC, 8'h80);
      pulse(0);
      wait_irq(24);
      chk_result(4'h3);
      pulse(2);
      rd(ST, 8'h43);
      wr(SC, 8'hA0);
      pulse(0);
      wait_irq(20);
      pulse(2);
      repeat (20) @(posedge core_clk_in);
      check("trigger while running", 8'(n0 + 2), 8'(n_starts));
      wr(TS, 8'h00);
      rd(TS, 8'h7F);
      pulse(0);
      repeat (10) @(posedge core_clk_in);
      check("pin with timer source", 8'(n0 + 2), 8'(n_starts));
      pulse(1);
      wait_irq(20);
      check("timer start", 8'(n0 + 3), 8'(n_starts));
      @(posedge core_clk_in);
      standby_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      standby_in <= 1'b0;
      rd(8'h06, 8'h00);
      rd(ST, 8'h00);
      rd(TS, 8'hFF);
      tally_and_finish();
   end
endmodule // adc_group_scan_control_tb
